// *** src/i2c_command_master.sv ***
// two-wire bus master run by one-hot commands over avalon-mm
// assumes open-drain pads resolved outside; pins are asynchronous
`timescale 1ns/1ps
`include "i2c_cmd_regs.svh"
`default_nettype none
module i2c_command_master
  import i2c_cmd_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic [4:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE_N_OUT,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N_OUT
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam logic [7:0] CYC_US = 8'(`NS_PER_US / `CLK_PERIOD_NS);
  state_t      state_q, state_d;
  kind_t       kind_q, kind_d;
  line_t       line_q, line_d;
  logic [1:0]  q_q, q_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d;
  logic [7:0]  status_q, status_d;
  logic [7:0]  rx_q, rx_d;
  logic        ack_q, ack_d;
  logic        err_q, err_d;
  logic        started_q, started_d;
  logic [7:0]  period_q, addr_q, tx_q;
  logic [15:0] cnt_q, cnt_d;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        scl_m_q, scl_s_q, sda_m_q, sda_s_q;
  // ----------------------------------------
  // bus slave decode
  // ----------------------------------------
  wire [2:0]  idx    = AVS_ADDRESS_IN[4:2];
  wire        req    = (AVS_READ_IN | AVS_WRITE_IN) & wait_q;
  wire        wr_go  = AVS_WRITE_IN & wait_q & AVS_BYTEENABLE_IN[0];
  wire        rd_go  = AVS_READ_IN & wait_q;
  wire [7:0]  wdat   = AVS_WRITEDATA_IN[7:0];
  wire        busy   = state_q != S_IDLE;
  wire [7:0]  rd_mux = (idx == `REG_PERIOD) ? period_q :
                       (idx == `REG_STATUS) ? status_q :
                       (idx == `REG_ADDR)   ? addr_q :
                       (idx == `REG_RXDATA) ? rx_q :
                       (idx == `REG_TXDATA) ? tx_q :
                       (idx == `REG_BUSY)   ? {7'h00, busy} : 8'h00;
  // ----------------------------------------
  // command decode
  // ----------------------------------------
  wire one_hot = (wdat != 8'h00) & ((wdat & (wdat - 8'h01)) == 8'h00)
                 & (wdat[7:6] == 2'h0);
  // zero period makes every command a no-op
  wire cmd_go  = wr_go & (idx == `REG_CMD) & !busy & (period_q != 8'h00);
  wire c_start = wdat[`CMD_START];
  wire c_stop  = wdat[`CMD_STOP];
  wire legal   = one_hot & (c_start | c_stop | (started_q & !status_q[7]));
  kind_t c_kind;
  assign c_kind = wdat[`CMD_ADDR] ? K_ADDR : wdat[`CMD_DATA] ? K_WR :
                  wdat[`CMD_RX_ACK] ? K_RXA : K_RXN;
  // address byte carries the direction bit in bit 0
  wire [7:0] byte_src = wdat[`CMD_ADDR] ? addr_q :
                        wdat[`CMD_DATA] ? tx_q : 8'hff;
  wire is_rx  = (kind_q == K_RXA) | (kind_q == K_RXN);
  wire dir_rd = addr_q[0];
  // completion codes, one bit meaning each
  wire [7:0] addr_st = err_q ? `STAT_A_ERR :
                       ack_q ? (dir_rd ? `STAT_RA_ACK : `STAT_WA_ACK) :
                       (dir_rd ? `STAT_RA_NACK : `STAT_WA_NACK);
  wire [7:0] wr_st   = err_q ? `STAT_WD_ERR :
                       ack_q ? `STAT_WD_ACK : `STAT_WD_NACK;
  wire [7:0] byte_st = (kind_q == K_ADDR) ? addr_st :
                       (kind_q == K_WR)   ? wr_st :
                       (kind_q == K_RXA)  ? `STAT_RD_ACK : `STAT_RD_NACK;
  // ----------------------------------------
  // quarter-bit timing
  // ----------------------------------------
  // floor of a quarter; bits run a hair short, never long
  wire [15:0] prod    = 16'(period_q) * 16'(CYC_US);
  wire [15:0] quarter = {2'h0, prod[15:2]};
  wire        last    = (cnt_q + 16'h0001) >= quarter;
  // slave may stretch the clock while it is released
  wire        stall   = (q_q == 2'h2) & !scl_s_q;
  wire        adv     = busy & last & !stall;
  assign cnt_d = (!busy | adv) ? 16'h0000 : last ? cnt_q : cnt_q + 16'h0001;
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    state_d   = state_q;
    kind_d    = kind_q;
    line_d    = line_q;
    q_d       = q_q;
    bit_d     = bit_q;
    sh_d      = sh_q;
    status_d  = status_q;
    rx_d      = rx_q;
    ack_d     = ack_q;
    err_d     = err_q;
    started_d = started_q;
    if (state_q == S_IDLE) begin
      if (cmd_go) begin
        q_d   = 2'h0;
        bit_d = 4'h0;
        err_d = 1'b0;
        ack_d = 1'b0;
        if (!legal) begin
          status_d = `STAT_GEN_ERR;
        end else if (c_start) begin
          state_d  = S_START;
          status_d = `STAT_IDLE;
        end else if (c_stop) begin
          status_d = `STAT_IDLE;
          if (started_q) begin
            state_d = S_STOP;
          end
        end else begin
          state_d  = S_BYTE;
          status_d = `STAT_IDLE;
          kind_d   = c_kind;
          sh_d     = byte_src;
        end
      end
    end else if (adv) begin
      q_d = q_q + 2'h1;
      case (state_q)
        S_START: begin
          case (q_q)
            2'h0: line_d.sda_rel = 1'b1;
            2'h1: line_d.scl_rel = 1'b1;
            2'h2: line_d.sda_rel = 1'b0;
            default: begin
              line_d.scl_rel = 1'b0;
              state_d   = S_IDLE;
              started_d = 1'b1;
              status_d  = started_q ? `STAT_RESTART : `STAT_START;
            end
          endcase
        end
        S_STOP: begin
          case (q_q)
            2'h0: line_d.sda_rel = 1'b0;
            2'h1: line_d.scl_rel = 1'b1;
            2'h2: line_d.sda_rel = 1'b1;
            default: begin
              state_d   = S_IDLE;
              started_d = 1'b0;
              status_d  = `STAT_IDLE;
            end
          endcase
        end
        S_BYTE: begin
          case (q_q)
            2'h0: begin
              // msb first, ack slot in ninth bit
              if (bit_q == `LAST_BIT) begin
                line_d.sda_rel = !is_rx | (kind_q == K_RXN);
              end else begin
                line_d.sda_rel = is_rx | sh_q[7];
              end
            end
            2'h1: line_d.scl_rel = 1'b1;
            2'h2: begin
              if (bit_q == `LAST_BIT) begin
                ack_d = !sda_s_q;
              end else begin
                sh_d = {sh_q[6:0], sda_s_q};
                if (!is_rx & line_q.sda_rel & !sda_s_q) begin
                  err_d = 1'b1;
                end
              end
            end
            default: begin
              line_d.scl_rel = 1'b0;
              if (bit_q == `LAST_BIT) begin
                state_d  = S_IDLE;
                status_d = byte_st;
                if (is_rx) begin
                  rx_d = sh_q;
                end
              end else begin
                bit_d = bit_q + 4'h1;
              end
            end
          endcase
        end
        default: state_d = S_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      state_q   <= S_IDLE;
      kind_q    <= K_ADDR;
      line_q    <= '{scl_rel: 1'b1, sda_rel: 1'b1};
      q_q       <= 2'h0;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      status_q  <= `STAT_IDLE;
      rx_q      <= 8'h00;
      ack_q     <= 1'b0;
      err_q     <= 1'b0;
      started_q <= 1'b0;
      cnt_q     <= 16'h0000;
    end else begin
      state_q   <= state_d;
      kind_q    <= kind_d;
      line_q    <= line_d;
      q_q       <= q_d;
      bit_q     <= bit_d;
      sh_q      <= sh_d;
      status_q  <= status_d;
      rx_q      <= rx_d;
      ack_q     <= ack_d;
      err_q     <= err_d;
      started_q <= started_d;
      cnt_q     <= cnt_d;
    end
  end
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      period_q <= 8'h00;
      addr_q   <= 8'h00;
      tx_q     <= 8'h00;
    end else if (wr_go) begin
      if (idx == `REG_PERIOD) period_q <= wdat;
      if (idx == `REG_ADDR)   addr_q   <= wdat;
      if (idx == `REG_TXDATA) tx_q     <= wdat;
    end
  end
  // one wait cycle per access keeps the slave answer fixed
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q  <= !req;
      rdata_q <= rd_go ? {24'h000000, rd_mux} : rdata_q;
    end
  end
  // pins are asynchronous: two stages before use
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      {scl_m_q, scl_s_q, sda_m_q, sda_s_q} <= 4'hf;
    end else begin
      {scl_m_q, scl_s_q} <= {SCL_IN, scl_m_q};
      {sda_m_q, sda_s_q} <= {SDA_IN, sda_m_q};
    end
  end
  assign AVS_READDATA_OUT    = rdata_q;
  assign AVS_WAITREQUEST_OUT = wait_q;
  assign SCL_OUT             = 1'b0;
  assign SDA_OUT             = 1'b0;
  assign SCL_OE_N_OUT        = line_q.scl_rel;
  assign SDA_OE_N_OUT        = line_q.sda_rel;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  wire byte_end = (state_q == S_BYTE) & adv & (q_q == 2'h3)
                  & (bit_q == `LAST_BIT);
  chk_zero_period: assert property (
    (wr_go & (idx == `REG_CMD) & !busy & (period_q == 8'h00))
    |=> !busy & $stable(status_q)) else $error("command ran at zero period");
  chk_start_code: assert property (
    (state_q == S_START) & adv & (q_q == 2'h3) |=> status_q ==
    ($past(started_q) ? `STAT_RESTART : `STAT_START))
    else $error("wrong start status");
  chk_start_shape: assert property (
    (state_q == S_START) & (q_q == 2'h3) |-> line_q.scl_rel & !line_q.sda_rel)
    else $error("start not sda low under high scl");
  chk_addr_msb: assert property (
    (state_q == S_BYTE) & (kind_q == K_ADDR) & (bit_q == 4'h0) & (q_q == 2'h1)
    |-> line_q.sda_rel == addr_q[7]) else $error("address msb wrong");
  chk_data_msb: assert property (
    (state_q == S_BYTE) & (kind_q == K_WR) & (bit_q == 4'h0) & (q_q == 2'h1)
    |-> line_q.sda_rel == tx_q[7]) else $error("data msb wrong");
  chk_rx_answer: assert property (
    (state_q == S_BYTE) & is_rx & (bit_q == `LAST_BIT) & (q_q != 2'h0)
    |-> line_q.sda_rel == (kind_q == K_RXN)) else $error("bad rx answer bit");
  chk_stop_end: assert property (
    (state_q == S_STOP) & adv & (q_q == 2'h3) |=> line_q.scl_rel
    & line_q.sda_rel & !started_q & (status_q == `STAT_IDLE))
    else $error("stop left bus held");
  chk_busy_status: assert property (
    busy |-> (status_q == `STAT_IDLE) & $stable(period_q))
    else $error("status moved mid phase");
  chk_sda_steady: assert property (
    (state_q == S_BYTE) & (q_q == 2'h2) |=> $stable(line_q.sda_rel))
    else $error("sda moved while scl high");
  chk_waddr_ack: assert property (
    byte_end & (kind_q == K_ADDR) & !err_q & ack_q & !addr_q[0]
    |=> status_q == `STAT_WA_ACK) else $error("write address ack code");
  cov_start: cover property ((state_q == S_START) ##[1:1000] !busy);
  cov_addr_ack: cover property (byte_end & (kind_q == K_ADDR) & ack_q);
  cov_rd_nack: cover property (byte_end & (kind_q == K_RXN));
  cov_stop: cover property ((state_q == S_STOP) & adv & (q_q == 2'h3));
endmodule
`default_nettype wire

// *** src/i2c_cmd_regs.svh ***
// register map, command bits, status codes and timing of the bus master
// assumes 32-bit avalon words, registers in the low byte
`ifndef I2C_CMD_REGS_SVH
`define I2C_CMD_REGS_SVH
// ----------------------------------------
// word index of each register
// ----------------------------------------
`define REG_PERIOD    3'h0
`define REG_CMD       3'h1
`define REG_STATUS    3'h2
`define REG_ADDR      3'h3
`define REG_RXDATA    3'h4
`define REG_TXDATA    3'h5
`define REG_BUSY      3'h6
// ----------------------------------------
// command bits
// ----------------------------------------
`define CMD_START     5
`define CMD_STOP      4
`define CMD_ADDR      3
`define CMD_DATA      2
`define CMD_RX_ACK    1
`define CMD_RX_NACK   0
// ----------------------------------------
// status codes
// ----------------------------------------
`define STAT_IDLE     8'h00
`define STAT_START    8'h01
`define STAT_RESTART  8'h02
`define STAT_WA_ACK   8'h34
`define STAT_RA_ACK   8'h2c
`define STAT_WA_NACK  8'h54
`define STAT_RA_NACK  8'h4c
`define STAT_A_ERR    8'he4
`define STAT_RD_ACK   8'h48
`define STAT_RD_NACK  8'h28
`define STAT_WD_ACK   8'h30
`define STAT_WD_NACK  8'h50
`define STAT_WD_ERR   8'hf0
`define STAT_GEN_ERR  8'hff
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define NS_PER_US     1000
`define LAST_BIT      4'h8
`endif

// *** src/i2c_cmd_pkg.sv ***
// types shared by the two-wire command master
// assumes the register header is included where constants are needed
`default_nettype none
package i2c_cmd_pkg;
  typedef enum logic [1:0] {S_IDLE, S_START, S_BYTE, S_STOP} state_t;
  typedef enum logic [1:0] {K_ADDR, K_WR, K_RXA, K_RXN} kind_t;
  typedef struct packed {
    logic scl_rel;
    logic sda_rel;
  } line_t;
endpackage
`default_nettype wire

// *** dv/i2c_slave_model.sv ***
// two-wire slave model: acks its address, keeps the last written byte, sends send_byte_in on every read byte
// assumes the bench resolves both open-drain wires with pull-ups
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model (
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [6:0] dev_addr_in,
  input  wire logic       ack_en_in,
  input  wire logic       clash_en_in,
  input  wire logic       stretch_en_in,
  input  wire logic [7:0] send_byte_in,
  output logic            scl_pull_out,
  output logic            sda_pull_out,
  output logic [7:0]      last_byte_out
);
  logic       active, fresh, is_addr, rd_mode, ack_q, mack, tick;
  logic       hold = 1'b0;
  logic [3:0] cnt;
  logic [7:0] sh;
  wire        tx_ph = rd_mode & ~is_addr;
  // ----------------------------------------
  // wire drive
  // ----------------------------------------
  // clash only while the count is 0: bit 7, the first bit, of a received byte, which also holds off a stop right after an acked byte
  assign sda_pull_out = !active ? 1'b0 :
                        (cnt == 4'h8) ? (~tx_ph & ack_q) :
                        tx_ph ? ~send_byte_in[3'h7 - cnt[2:0]] :
                        (clash_en_in & (cnt == 4'h0)); // msb first
  assign scl_pull_out = hold;
  initial begin
    {active, fresh, is_addr, rd_mode, ack_q, mack} = '0;
    {cnt, sh, last_byte_out} = '0;
    tick = 1'b0;
    #7;
    forever #32 tick = ~tick;
  end
  // ----------------------------------------
  // bus events
  // ----------------------------------------
  always @(negedge sda_in) if (scl_in) begin
    {active, fresh, is_addr} = 3'b111;
    rd_mode = 1'b0;
    cnt = 4'h0;
  end
  always @(posedge sda_in) if (scl_in) active = 1'b0;
  always @(posedge scl_in) begin
    if (active && !fresh && cnt < 4'h8 && !tx_ph) sh = {sh[6:0], sda_in};
    if (active && cnt == 4'h8 && tx_ph) mack = ~sda_in;
  end
  always @(negedge scl_in) begin
    if (fresh) fresh = 1'b0;
    else if (active && cnt == 4'h7) begin
      cnt = 4'h8;
      ack_q = is_addr ? (sh[7:1] == dev_addr_in) & ack_en_in : ack_en_in;
      if (!is_addr && !tx_ph) last_byte_out = sh;
    end else if (active && cnt == 4'h8) begin
      cnt = 4'h0;
      if (is_addr) rd_mode = sh[0];
      if ((is_addr || !tx_ph) ? !ack_q : !mack) active = 1'b0;
      is_addr = 1'b0;
    end else if (active) cnt = cnt + 4'h1;
  end
  // slow slave: holds the clock low past the master's own release
  always @(negedge scl_in) if (stretch_en_in) begin
    hold = 1'b1;
    repeat (12) @(posedge tick);
    hold = 1'b0;
  end
endmodule
`default_nettype wire

// *** dv/i2c_command_master_tb.sv ***
// bench for the two-wire command master with a slave model on the wires
// assumes the register header and package are compiled ahead of it
`timescale 1ns/1ps
`include "i2c_cmd_regs.svh"
`default_nettype none
module i2c_command_master_tb;
  localparam logic [6:0] SLV = 7'h50;
  logic        clk, rst_n, rd, wr, ack_en, clash_en, stretch_en;
  logic [4:0]  addr;
  logic [31:0] wdata;
  logic [7:0]  v, send_byte;
  logic [3:0]  be;
  time         scl_last, scl_gap;
  wire  [31:0] rdata;
  wire  [7:0]  last_byte;
  wire         wait_req, scl_o, scl_oe_n, sda_o, sda_oe_n, scl_p, sda_p;
  wire         scl_w = (scl_oe_n | scl_o) & ~scl_p;
  wire         sda_w = (sda_oe_n | sda_o) & ~sda_p;
  int          errors, num_checks, k;
  i2c_command_master dut (.CLK_IN(clk), .RST_N_IN(rst_n),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req),
    .SCL_IN(scl_w), .SCL_OUT(scl_o), .SCL_OE_N_OUT(scl_oe_n),
    .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE_N_OUT(sda_oe_n));
  i2c_slave_model slave (.scl_in(scl_w), .sda_in(sda_w),
    .dev_addr_in(SLV), .ack_en_in(ack_en), .clash_en_in(clash_en),
    .stretch_en_in(stretch_en), .send_byte_in(send_byte),
    .scl_pull_out(scl_p), .sda_pull_out(sda_p),
    .last_byte_out(last_byte));
  // time between clock rises, for the bit length check
  always @(posedge scl_w) begin
    scl_gap = $time - scl_last;
    scl_last = $time;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    rd <= ~w;
    wr <= w;
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    // no cycle count assumed; only the watchdog ends this wait
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wreg(input logic [2:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rchk(input logic [2:0] idx, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(q, e);
  endtask
  // poll busy, bounded, then compare the status byte
  task automatic done(input logic [7:0] e);
    logic [7:0] q;
    int n;
    n = 0;
    q = 8'h01;
    while (q[0] !== 1'b0 && n < 4000) begin
      bus(1'b0, `REG_BUSY, 8'h00, q);
      n++;
    end
    if (n >= 4000) begin
      errors++;
      finish_test();
    end
    rchk(`REG_STATUS, e);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] e);
    wreg(`REG_CMD, c);
    done(e);
  endtask
  task automatic send(input logic [7:0] d, input logic [7:0] e);
    wreg(`REG_TXDATA, d);
    cmd(8'h04, e);
  endtask
  task automatic adr(input logic rw, input logic [7:0] e);
    wreg(`REG_ADDR, {SLV, rw});
    cmd(8'h08, e);
  endtask
  // status from bit meanings: address, read mode, answer seen
  function automatic logic [7:0] stat(input logic a, input logic r,
                                      input logic ackd);
    stat = {1'b0, ~ackd, ackd, ~r, r, a, 2'b00};
  endfunction
  // whole quarters of the microsecond count, so a bit runs a hair short
  function automatic int bit_cycles(input int p);
    bit_cycles = 4 * ((p * `NS_PER_US / `CLK_PERIOD_NS) / 4);
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    finish_test();
  end
  initial begin
    {rst_n, rd, wr, clash_en, stretch_en, addr, wdata} = '0;
    {errors, num_checks} = '0;
    ack_en = 1'b1;
    send_byte = 8'h00;
    be = 4'hf;
    k = $urandom(32'hdb4f);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 8; k++) rchk(3'(k), 8'h00);
    cmd(8'h20, `STAT_IDLE); // period zero keeps the bus still
    check({6'h00, scl_w, sda_w}, 8'h03);
    wreg(`REG_PERIOD, 8'h01);
    rchk(`REG_PERIOD, 8'h01);
    be <= 4'he;
    wreg(`REG_PERIOD, 8'h77); // low byte lane off: dropped
    be <= 4'hf;
    rchk(`REG_PERIOD, 8'h01);
    wreg(`REG_STATUS, 8'h5a);
    rchk(`REG_STATUS, `STAT_IDLE);
    cmd(8'h20, `STAT_START);
    adr(1'b0, stat(1'b1, 1'b0, 1'b1));
    for (k = 0; k < 3; k++) begin
      v = 8'($urandom());
      stretch_en <= (k == 1);
      send(v, stat(1'b0, 1'b0, 1'b1));
      check(last_byte, v);
    end
    check(8'(scl_gap / `CLK_PERIOD_NS), 8'(bit_cycles(1)));
    cmd(8'h20, `STAT_RESTART);
    adr(1'b1, stat(1'b1, 1'b1, 1'b1));
    for (k = 0; k < 3; k++) begin
      send_byte <= 8'($urandom());
      cmd((k == 2) ? 8'h01 : 8'h02, stat(1'b0, 1'b1, k == 2));
      rchk(`REG_RXDATA, send_byte);
    end
    cmd(8'h10, `STAT_IDLE);
    check({6'h00, scl_w, sda_w}, 8'h03);
    ack_en <= 1'b0;
    cmd(8'h20, `STAT_START);
    adr(1'b0, stat(1'b1, 1'b0, 1'b0));
    cmd(8'h20, `STAT_RESTART);
    adr(1'b1, stat(1'b1, 1'b1, 1'b0));
    ack_en <= 1'b1;
    cmd(8'h20, `STAT_RESTART);
    adr(1'b0, stat(1'b1, 1'b0, 1'b1));
    ack_en <= 1'b0;
    send(8'h3c, stat(1'b0, 1'b0, 1'b0));
    ack_en <= 1'b1;
    cmd(8'h20, `STAT_RESTART);
    clash_en <= 1'b1;
    adr(1'b0, `STAT_A_ERR);
    clash_en <= 1'b0;
    send(8'h81, `STAT_GEN_ERR); // byte phase with error pending
    cmd(8'h10, `STAT_IDLE);
    cmd(8'h20, `STAT_START);
    adr(1'b0, stat(1'b1, 1'b0, 1'b1));
    clash_en <= 1'b1;
    send(8'h81, `STAT_WD_ERR);
    clash_en <= 1'b0;
    cmd(8'h10, `STAT_IDLE);
    cmd(8'h30, `STAT_GEN_ERR); // two bits at once
    cmd(8'h04, `STAT_GEN_ERR); // byte phase before any start
    cmd(8'h10, `STAT_IDLE);
    wreg(`REG_CMD, 8'h20);
    rchk(`REG_STATUS, `STAT_IDLE);
    wreg(`REG_CMD, 8'h10); // dropped while busy
    done(`STAT_START);
    cmd(8'h10, `STAT_IDLE);
    finish_test();
  end
endmodule
`default_nettype wire
